// file: shared/tmf_cfg.svh
// Constants for the trace message formatter: offsets, fields, codes, reset values
`ifndef TMF_CFG_SVH
`define TMF_CFG_SVH
`define TMF_REG_CTRL 8'h00
`define TMF_REG_STATUS 8'h04
`define TMF_CTRL_OT_BIT 0
`define TMF_CTRL_DT_BIT 1
`define TMF_CTRL_RESET 2'h0
`define TMF_ST_EMPTY_BIT 0
`define TMF_ST_QEN_BIT 1
`define TMF_ST_OVR_BIT 2
`define TMF_ST_DSYNC_LSB 4
`define TMF_ST_PSYNC_LSB 6
`define TMF_ST_CNT_LSB 8
`define TMF_ST_WSEL_LSB 16
`define TMF_TCODE_W 6
`define TMF_TCODE_DS 6'h00
`define TMF_TCODE_OT 6'h02
`define TMF_TCODE_DW 6'h05
`define TMF_TCODE_DR 6'h06
`define TMF_TCODE_ERR 6'h08
`define TMF_TCODE_DWS 6'h0d
`define TMF_TCODE_DRS 6'h0e
`define TMF_ECODE_DS_OVR 5'h18
`define TMF_ECODE_W 5
`define TMF_DS_W 32
`define TMF_OT_W 16
`define TMF_SIZE_W 2
`define TMF_MSEO_NT 2'h0
`define TMF_MSEO_EP 2'h1
`define TMF_MSEO_EM 2'h3
`define TMF_STRAP_SETTLE 2'h2
`endif

// file: shared/tmf_pkg.sv
// Types shared by the trace message formatter modules
package tmf_pkg;
	typedef enum logic [1:0] {KIND_ERR, KIND_DS, KIND_OT, KIND_DT} tmf_kind_type;
	// Per-engine event bundle; flags bit0..7 = link, m1, m2, t1, t2, pin, cf1, cf0
	typedef struct packed {
		logic [31:0] debug_status_word;
		logic in_debug;
		logic svc_start;
		logic [4:0] chan;
		logic [2:0] host_service_request;
		logic [7:0] flags;
		logic idle;
		logic dt_valid;
		logic dt_read;
		logic [1:0] dt_size;
		logic [13:0] dt_addr;
		logic [31:0] dt_data;
	} tmf_eng_ev_type;
	// One snapshot in the event queue
	typedef struct packed {
		tmf_kind_type kind;
		logic eng;
		logic sync;
		logic rd;
		logic [1:0] size;
		logic [13:0] addr;
		logic [31:0] data;
	} tmf_entry_type;
endpackage

// file: design/tmf_sync.sv
// Two-flop synchroniser for pins and foreign-clock levels
`timescale 1ns/1ps
module tmf_sync #(
	parameter int W = 1
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_r <= '0;
			q_r <= '0;
		end
		else
		begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule // tmf_sync

// file: design/tmf_packer.sv
// Packs one message into port-width beats with end-of-packet/message signalling
`timescale 1ns/1ps
`include "tmf_cfg.svh"
module tmf_packer import tmf_pkg::*; #(
	parameter int MDO_W = 16
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic tick,
	input wire logic [63:0] fix_bits,
	input wire logic [6:0] fix_len,
	input wire logic va_en,
	input wire logic [31:0] va,
	input wire logic vb_en,
	input wire logic [31:0] vb,
	input wire logic [1:0] wsel,
	output logic busy,
	output logic [MDO_W-1:0] mdo,
	output logic [1:0] mseo
);
	if (MDO_W < 16) begin : g_bad_w
		$error("tmf_packer: MDO_W must be at least 16");
	end

	// Bits sent for a variable packet: up to the top set bit, at least one
	function automatic logic [7:0] msb_len(input logic [31:0] v);
		logic [7:0] n;
		n = 8'h01;
		for (int i = 0; i < 32; i++)
			if (v[i])
				n = 8'(i + 1);
		return n;
	endfunction

	function automatic logic [7:0] rnd(input logic [7:0] x, input logic [7:0] w);
		return (x + w - 8'h01) & ~(w - 8'h01);
	endfunction

	logic [127:0] msg_r, msg_nxt;
	logic [7:0] tot_r, tot_nxt, ep_r, ep_nxt, w_r, w_nxt, off_r, off_nxt;
	logic busy_r, busy_nxt;
	logic [MDO_W-1:0] mdo_r, mdo_nxt;
	logic [1:0] mseo_r, mseo_nxt;
	logic [7:0] w, a_end, tot, b_end;
	logic [127:0] beat;

	// Layout: variable A may start mid-word after the fixed group, B starts on a boundary
	always_comb
	begin
		w = (wsel == 2'h0) ? 8'h04 : (wsel == 2'h1) ? 8'h08 : 8'h10;
		a_end = rnd({1'b0, fix_len} + msb_len(va), w);
		b_end = rnd(a_end + msb_len(vb), w);
		tot = vb_en ? b_end : va_en ? a_end : rnd({1'b0, fix_len}, w);
		if (tot <= w)
			tot = w << 1;
		msg_nxt = msg_r;
		tot_nxt = tot_r;
		ep_nxt = ep_r;
		w_nxt = w_r;
		off_nxt = off_r;
		busy_nxt = busy_r;
		mdo_nxt = mdo_r;
		mseo_nxt = mseo_r;
		beat = msg_r >> off_r;
		if (start && !busy_r)
		begin
			// Zeros above each packet's top bit give the padding for free
			msg_nxt = {64'h0, fix_bits}
				| (va_en ? ({96'h0, va} << fix_len) : 128'h0)
				| (vb_en ? ({96'h0, vb} << a_end) : 128'h0);
			tot_nxt = tot;
			ep_nxt = (va_en && vb_en) ? a_end : 8'h00;
			w_nxt = w;
			off_nxt = 8'h00;
			busy_nxt = 1'b1;
		end
		else if (tick && busy_r)
		begin
			mdo_nxt = beat[MDO_W-1:0] & ~({MDO_W{1'b1}} << w_r);
			off_nxt = off_r + w_r;
			busy_nxt = (off_nxt != tot_r);
			if (off_nxt == tot_r)
				mseo_nxt = `TMF_MSEO_EM;
			else if (off_nxt == ep_r)
				mseo_nxt = `TMF_MSEO_EP;
			else
				mseo_nxt = `TMF_MSEO_NT;
		end
		else if (tick)
		begin
			mdo_nxt = '0;
			mseo_nxt = `TMF_MSEO_EM;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			msg_r <= '0;
			tot_r <= 8'h00;
			ep_r <= 8'h00;
			w_r <= 8'h10;
			off_r <= 8'h00;
			busy_r <= 1'b0;
			mdo_r <= '0;
			mseo_r <= `TMF_MSEO_EM;
		end
		else
		begin
			msg_r <= msg_nxt;
			tot_r <= tot_nxt;
			ep_r <= ep_nxt;
			w_r <= w_nxt;
			off_r <= off_nxt;
			busy_r <= busy_nxt;
			mdo_r <= mdo_nxt;
			mseo_r <= mseo_nxt;
		end
	end

	assign busy = busy_r;
	assign mdo = mdo_r;
	assign mseo = mseo_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	lanes_zero_a: assert property ((mdo_r & ({MDO_W{1'b1}} << w_r)) == '0) else $error("lanes above port width driven");
	end_msg_a: assert property ($fell(busy_r) |-> mseo_r == `TMF_MSEO_EM) else $error("message ended without end code");
endmodule // tmf_packer

// file: design/tmf_formatter.sv
// Trace message formatter: event queue, message build and aux port output
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "tmf_cfg.svh"
module tmf_formatter import tmf_pkg::*; #(
	parameter int DEPTH = 16,
	parameter int SRC_W = 3,
	parameter int MDO_W = 16,
	parameter logic [SRC_W-1:0] SRC_ENG0 = 3'h2,
	parameter logic [SRC_W-1:0] SRC_ENG1 = 3'h3
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire tmf_eng_ev_type eng0_ev,
	input wire tmf_eng_ev_type eng1_ev,
	input wire logic [1:0] pt_sync_ack,
	output logic [1:0] pt_sync_req,
	input wire logic [1:0] mdo_width_strap,
	input wire logic link_clk,
	input wire logic aux_grant,
	output logic aux_req,
	output logic [MDO_W-1:0] mdo,
	output logic [1:0] mseo
);
	localparam int NC = 7;
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 * NC || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("tmf_formatter: DEPTH must be a power of two of at least 14");
	end
	if (SRC_W < 1 || SRC_W > 8) begin : g_bad_src
		$error("tmf_formatter: SRC_W must be 1 to 8");
	end

	tmf_entry_type q_mem [DEPTH];
	tmf_eng_ev_type ev [2];
	logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic qen_r, qen_nxt, ovr_r, ovr_nxt;
	logic [1:0][31:0] ds_last_r, ds_last_nxt;
	logic [1:0] dbg_last_r, dbg_last_nxt, dt_sync_r, dt_sync_nxt, pt_sync_r, pt_sync_nxt;
	logic [1:0] ds_chg, dbg_exit;
	logic [NC-1:0] cand_v;
	tmf_entry_type cand_e [NC];
	logic [PW-1:0] cand_slot [NC];
	logic [3:0] n_wr;
	logic deq;
	logic [1:0] ctrl_r, ctrl_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt, status;
	logic [1:0] wsel_r, wsel_nxt, settle_r, settle_nxt, strap_s;
	logic link_s, link_d_r, tick;
	tmf_entry_type head;
	logic [5:0] tcode;
	logic [SRC_W-1:0] src;
	logic [31:0] pay;
	logic [6:0] plen;
	logic [63:0] fix_bits;
	logic [6:0] fix_len;
	logic va_en, vb_en, pk_busy;

	assign ev[0] = eng0_ev;
	assign ev[1] = eng1_ev;

	tmf_sync #(.W(1)) u_link_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.d(link_clk),
		.q(link_s)
	);

	tmf_sync #(.W(2)) u_strap_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.d(mdo_width_strap),
		.q(strap_s)
	);

	// Snapshot candidates in fixed priority order; all of one cycle go in together
	always_comb
	begin
		for (int e = 0; e < 2; e++)
		begin
			ds_chg[e] = ev[e].debug_status_word != ds_last_r[e];
			dbg_exit[e] = dbg_last_r[e] & ~ev[e].in_debug;
		end
		for (int i = 0; i < NC; i++)
			cand_e[i] = '0;
		cand_v[0] = ovr_r & qen_r;
		cand_e[0].kind = KIND_ERR;
		for (int e = 0; e < 2; e++)
		begin
			cand_v[1 + e] = qen_r & ds_chg[e];
			cand_e[1 + e].kind = KIND_DS;
			cand_e[1 + e].eng = 1'(e);
			cand_e[1 + e].data = ev[e].debug_status_word;
			cand_v[3 + e] = qen_r & ctrl_r[`TMF_CTRL_OT_BIT]
				& (ev[e].svc_start | ev[e].idle);
			cand_e[3 + e].kind = KIND_OT;
			cand_e[3 + e].eng = 1'(e);
			if (ev[e].svc_start)
				cand_e[3 + e].data = {16'h0, ev[e].flags, ev[e].host_service_request, ev[e].chan};
			// Idle reports a zero payload so the tool sees the engine stop
			else
				cand_e[3 + e].data = 32'h0;
			cand_v[5 + e] = qen_r & ctrl_r[`TMF_CTRL_DT_BIT] & ev[e].dt_valid;
			cand_e[5 + e].kind = KIND_DT;
			cand_e[5 + e].eng = 1'(e);
			cand_e[5 + e].sync = dt_sync_r[e];
			cand_e[5 + e].rd = ev[e].dt_read;
			cand_e[5 + e].size = ev[e].dt_size;
			cand_e[5 + e].addr = ev[e].dt_addr;
			cand_e[5 + e].data = ev[e].dt_data;
		end
		n_wr = 4'h0;
		for (int i = 0; i < NC; i++)
		begin
			cand_slot[i] = wr_ptr_r + PW'(n_wr);
			n_wr = n_wr + {3'h0, cand_v[i]};
		end
	end

	// Queue bookkeeping, overrun and synchronisation flags
	always_comb
	begin
		deq = aux_grant & ~pk_busy & (cnt_r != '0);
		wr_ptr_nxt = wr_ptr_r + PW'(n_wr);
		rd_ptr_nxt = rd_ptr_r + PW'(deq);
		cnt_nxt = cnt_r + CW'(n_wr) - CW'(deq);
		// Room for a whole cycle's snapshots is kept; once closed it reopens only when empty
		qen_nxt = (cnt_nxt == '0) | (qen_r & (cnt_nxt <= CW'(DEPTH - NC)));
		ovr_nxt = (~qen_r & |ds_chg) | (ovr_r & ~cand_v[0]);
		for (int e = 0; e < 2; e++)
		begin
			ds_last_nxt[e] = ev[e].debug_status_word;
			dbg_last_nxt[e] = ev[e].in_debug;
			dt_sync_nxt[e] = dbg_exit[e] | (dt_sync_r[e] & ~cand_v[5 + e]);
			pt_sync_nxt[e] = dbg_exit[e] | (pt_sync_r[e] & ~pt_sync_ack[e]);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
			qen_r <= 1'b1;
			ovr_r <= 1'b0;
			ds_last_r <= '0;
			dbg_last_r <= 2'h0;
			dt_sync_r <= 2'h3;
			pt_sync_r <= 2'h3;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			cnt_r <= cnt_nxt;
			qen_r <= qen_nxt;
			ovr_r <= ovr_nxt;
			ds_last_r <= ds_last_nxt;
			dbg_last_r <= dbg_last_nxt;
			dt_sync_r <= dt_sync_nxt;
			pt_sync_r <= pt_sync_nxt;
		end
	end

	// Queue storage has no reset; entries are read only below the count
	always_ff @(posedge sys_clk)
	begin
		for (int i = 0; i < NC; i++)
			if (cand_v[i])
				q_mem[cand_slot[i]] <= cand_e[i];
	end

	// Build the message head: TCODE first, then SRC, then payload
	always_comb
	begin
		head = q_mem[rd_ptr_r];
		src = head.eng ? SRC_ENG1 : SRC_ENG0;
		va_en = 1'b0;
		vb_en = 1'b0;
		case (head.kind)
			KIND_ERR:
			begin
				tcode = `TMF_TCODE_ERR;
				src = SRC_ENG0;
				pay = {27'h0, `TMF_ECODE_DS_OVR};
				plen = 7'(`TMF_ECODE_W);
			end
			KIND_DS:
			begin
				tcode = `TMF_TCODE_DS;
				pay = head.data;
				plen = 7'(`TMF_DS_W);
			end
			KIND_OT:
			begin
				tcode = `TMF_TCODE_OT;
				pay = head.data;
				plen = 7'(`TMF_OT_W);
			end
			default:
			begin
				if (head.sync)
					tcode = head.rd ? `TMF_TCODE_DRS : `TMF_TCODE_DWS;
				else
					tcode = head.rd ? `TMF_TCODE_DR : `TMF_TCODE_DW;
				pay = {30'h0, head.size};
				plen = 7'(`TMF_SIZE_W);
				va_en = 1'b1;
				vb_en = 1'b1;
			end
		endcase
		fix_bits = {58'h0, tcode} | (64'(src) << `TMF_TCODE_W)
			| (64'(pay) << (`TMF_TCODE_W + SRC_W));
		fix_len = 7'(`TMF_TCODE_W + SRC_W) + plen;
	end

	tmf_packer #(.MDO_W(MDO_W)) u_packer (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.start(deq),
		.tick(tick),
		.fix_bits(fix_bits),
		.fix_len(fix_len),
		.va_en(va_en),
		.va({18'h0, head.addr}),
		.vb_en(vb_en),
		.vb(head.data),
		.wsel(wsel_r),
		.busy(pk_busy),
		.mdo(mdo),
		.mseo(mseo)
	);

	// Link clock edges pace the beats; width strap is caught once after reset
	always_comb
	begin
		tick = link_s & ~link_d_r;
		// Strap is taken once, at the third edge, when the synchroniser holds the pin value
		settle_nxt = (settle_r == 2'h3) ? settle_r : settle_r + 2'h1;
		wsel_nxt = (settle_r == `TMF_STRAP_SETTLE) ? strap_s : wsel_r;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			link_d_r <= 1'b0;
			settle_r <= 2'h0;
			wsel_r <= 2'h2;
		end
		else
		begin
			link_d_r <= link_s;
			settle_r <= settle_nxt;
			wsel_r <= wsel_nxt;
		end
	end

	// Avalon slave: one wait cycle on every access, unmapped reads give zero
	always_comb
	begin
		status = 32'h0;
		status[`TMF_ST_EMPTY_BIT] = (cnt_r == '0);
		status[`TMF_ST_QEN_BIT] = qen_r;
		status[`TMF_ST_OVR_BIT] = ovr_r;
		status[`TMF_ST_DSYNC_LSB +: 2] = dt_sync_r;
		status[`TMF_ST_PSYNC_LSB +: 2] = pt_sync_r;
		status[`TMF_ST_CNT_LSB +: 8] = 8'(cnt_r);
		status[`TMF_ST_WSEL_LSB +: 2] = wsel_r;
		ack_nxt = (avs_read | avs_write) & ~ack_r;
		ctrl_nxt = ctrl_r;
		rdata_nxt = rdata_r;
		// Write lands on the edge where waitrequest is seen low, never earlier
		if (ack_r && avs_write)
		begin
			if (avs_address == `TMF_REG_CTRL && avs_byteenable[0])
				ctrl_nxt = avs_writedata[1:0];
		end
		else if (ack_nxt && avs_read)
		begin
			if (avs_address == `TMF_REG_CTRL)
				rdata_nxt = {30'h0, ctrl_r};
			else if (avs_address == `TMF_REG_STATUS)
				rdata_nxt = status;
			else
				rdata_nxt = 32'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_r <= `TMF_CTRL_RESET;
			ack_r <= 1'b0;
			rdata_r <= 32'h0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata = rdata_r;
	assign aux_req = (cnt_r != '0) | pk_busy;
	assign pt_sync_req = pt_sync_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	no_grant_a: assert property (!aux_grant |=> cnt_r >= $past(cnt_r)) else $error("queue read without grant");
	ds_enq_a: assert property (qen_r && ds_chg[0] |=> q_mem[$past(cand_slot[1])].kind == KIND_DS) else $error("status change not queued");
	ovr_set_a: assert property (!qen_r && |ds_chg |=> ovr_r) else $error("overrun not flagged");
	err_first_a: assert property (cand_v[0] |=> q_mem[$past(wr_ptr_r)].kind == KIND_ERR) else $error("error not queued first");
	sync_exit_a: assert property (dbg_exit[0] && !cand_v[5] |=> dt_sync_r[0] && pt_sync_r[0]) else $error("no sync after debug exit");
	err_code_a: assert property (deq && head.kind == KIND_ERR |-> fix_bits[`TMF_TCODE_W + SRC_W +: 5] == 5'h18 && fix_bits[5:0] == 6'h08) else $error("bad error message");
	ot_idle_a: assert property (cand_v[3] && !ev[0].svc_start |-> cand_e[3].data == 32'h0) else $error("idle ownership payload not zero");
	dt_size_a: assert property (deq && head.kind == KIND_DT |-> fix_len == 7'(8 + SRC_W)) else $error("data size field not 2 bits");
	start_busy_a: assert property (deq |=> pk_busy [*2]) else $error("message not started");

	ds_msg_c: cover property (deq && head.kind == KIND_DS);
	ovr_msg_c: cover property (deq && head.kind == KIND_ERR);
	ot_both_c: cover property (cand_v[3] && cand_v[4]);
	dt_sync_c: cover property (deq && head.kind == KIND_DT && head.sync);
endmodule // tmf_formatter

// file: dv/tmf_tool_model.sv
// Development tool model: makes the port clock and logs trace beats
`timescale 1ns/1ps
module tmf_tool_model #(
	parameter int MDO_W = 16
)(
	input wire logic [MDO_W-1:0] mdo,
	input wire logic [1:0] mseo,
	output logic link_clk
);
	logic [17:0] beats[$];
	logic [1:0] prev_r;
	int msgs;
	// Free-running port clock, offset so it never lines up with sys_clk
	initial
	begin
		link_clk = 1'h0;
		prev_r = 2'h3;
		msgs = 0;
		#13;
		forever
			#40 link_clk = ~link_clk;
	end
	// Sample mid-beat; idle beats after an end of message are not logged
	always @(negedge link_clk)
	begin
		if (mseo != 2'h3 || prev_r != 2'h3)
		begin
			beats.push_back({mseo, 16'(mdo)});
			if (mseo == 2'h3)
				msgs++;
		end
		prev_r = mseo;
	end
endmodule // tmf_tool_model

// file: dv/trace_message_formatter_test.sv
// Self-checking bench for the trace message formatter
`timescale 1ns/1ps
module trace_message_formatter_test import tmf_pkg::*;;
	localparam logic [2:0] S0 = 3'h2;
	localparam logic [2:0] S1 = 3'h3;
	logic sys_clk = 1'h0;
	logic reset_n = 1'h0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	tmf_eng_ev_type ev0 = '0;
	tmf_eng_ev_type ev1 = '0;
	logic [1:0] pt_sync_ack = 2'h0;
	logic [1:0] pt_sync_req;
	logic [1:0] strap = 2'h2;
	logic link_clk;
	logic aux_grant = 1'h1;
	logic aux_req;
	logic [15:0] mdo;
	logic [1:0] mseo;
	logic [31:0] rd;
	int miscompares = 0;
	int checks = 0;
	int taken = 0;
	int w = 16;
	// 125 MHz system clock
	always #4 sys_clk = ~sys_clk;
	tmf_formatter #(.SRC_W(3), .MDO_W(16), .SRC_ENG0(S0), .SRC_ENG1(S1)) uut (
		.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .eng0_ev(ev0), .eng1_ev(ev1),
		.pt_sync_ack(pt_sync_ack), .pt_sync_req(pt_sync_req), .mdo_width_strap(strap),
		.link_clk(link_clk), .aux_grant(aux_grant), .aux_req(aux_req), .mdo(mdo), .mseo(mseo));
	tmf_tool_model #(.MDO_W(16)) tool (.mdo(mdo), .mseo(mseo), .link_clk(link_clk));
	task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_beat(input string n, input logic [17:0] e, input logic [17:0] g);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One Avalon access; request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'h0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		if (n == 50)
		begin
			miscompares++;
			$display("BAD bus exp ack got none");
		end
	endtask
	task automatic do_reset(input logic [1:0] s);
		@(posedge sys_clk);
		reset_n <= 1'h0;
		strap <= s;
		ev0 <= '0;
		ev1 <= '0;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'h1;
		repeat (6) @(posedge sys_clk);
	endtask
	function automatic logic [63:0] mk(input logic [5:0] tc, input logic [2:0] s,
		input logic [31:0] x);
		return (64'(x) << 9) | (64'(s) << 6) | 64'(tc);
	endfunction
	task automatic wait_msg();
		int k;
		k = 0;
		while (tool.msgs <= taken && k < 4000)
		begin
			@(posedge sys_clk);
			k++;
		end
		if (k == 4000)
		begin
			miscompares++;
			$display("BAD message exp beats got none");
		end
	endtask
	// Builds the expected beats: fixed bits packed, variable packets trimmed and padded
	task automatic expect_msg(input string n, input logic [63:0] fx, input int fl,
		input int nv, input logic [31:0] va, input logic [31:0] vb);
		logic [17:0] q[$];
		logic [15:0] word;
		logic [63:0] v;
		int p;
		int len;
		word = 16'h0;
		p = 0;
		for (int j = 0; j <= nv; j++)
		begin
			v = (j == 0) ? fx : (j == 1) ? 64'(va) : 64'(vb);
			len = fl;
			if (j > 0)
				len = 1;
			for (int b = 0; b < 32 && j > 0; b++)
				if (v[b])
					len = b + 1;
			for (int b = 0; b < len; b++)
			begin
				word[p] = v[b];
				p++;
				if (p == w)
				begin
					q.push_back({2'h0, word});
					word = 16'h0;
					p = 0;
				end
			end
			if (p > 0 && (j > 0 || nv == 0))
			begin
				q.push_back({2'h0, word});
				word = 16'h0;
				p = 0;
			end
			if (j > 0)
				q[$][17:16] = 2'h1;
		end
		if (q.size() == 1)
			q.push_back(18'h0);
		q[$][17:16] = 2'h3;
		wait_msg();
		if (tool.msgs > taken)
		begin
			taken++;
			foreach (q[i])
				chk_beat(n, q[i], tool.beats.pop_front());
		end
	endtask
	// Data trace event from one engine, one cycle wide
	task automatic dt(input logic e, input logic r, input logic [1:0] s,
		input logic [13:0] a, input logic [31:0] d);
		tmf_eng_ev_type t;
		t = e ? ev1 : ev0;
		t.dt_valid = 1'h1;
		t.dt_read = r;
		t.dt_size = s;
		t.dt_addr = a;
		t.dt_data = d;
		@(posedge sys_clk);
		if (e)
			ev1 <= t;
		else
			ev0 <= t;
		t.dt_valid = 1'h0;
		@(posedge sys_clk);
		if (e)
			ev1 <= t;
		else
			ev0 <= t;
	endtask
	task automatic s_regs(input logic [31:0] st);
		bus(1'h0, 8'h00, 32'h0);
		chk_reg("ctrl", 32'h0, rd);
		bus(1'h0, 8'h04, 32'h0);
		chk_reg("status", st, rd);
		bus(1'h0, 8'h08, 32'h0);
		chk_reg("unmapped", 32'h0, rd);
		bus(1'h1, 8'h00, 32'h3);
		bus(1'h0, 8'h00, 32'h0);
		chk_reg("ctrl wr", 32'h3, rd);
		@(posedge sys_clk);
		ev0.debug_status_word <= 32'h21;
		expect_msg("ds", mk(6'h00, S0, 32'h21), 41, 0, 0, 0);
	endtask
	task automatic s_ot();
		chk_reg("psync", 32'h3, 32'(pt_sync_req));
		@(posedge sys_clk);
		pt_sync_ack <= 2'h1;
		ev1.debug_status_word <= 32'h5;
		ev0.svc_start <= 1'h1;
		ev0.chan <= 5'h13;
		ev0.host_service_request <= 3'h5;
		ev0.flags <= 8'h83;
		@(posedge sys_clk);
		pt_sync_ack <= 2'h0;
		ev0.svc_start <= 1'h0;
		ev1.svc_start <= 1'h1;
		ev1.chan <= 5'h07;
		ev1.host_service_request <= 3'h2;
		ev1.flags <= 8'h06;
		@(posedge sys_clk);
		ev1.svc_start <= 1'h0;
		ev0.idle <= 1'h1;
		@(posedge sys_clk);
		ev0.idle <= 1'h0;
		chk_reg("psync ack", 32'h2, 32'(pt_sync_req));
		expect_msg("ds first", mk(6'h00, S1, 32'h5), 41, 0, 0, 0);
		expect_msg("ot eng0", mk(6'h02, S0, 32'h83b3), 25, 0, 0, 0);
		expect_msg("ot eng1", mk(6'h02, S1, 32'h0647), 25, 0, 0, 0);
		expect_msg("ot idle", mk(6'h02, S0, 32'h0), 25, 0, 0, 0);
	endtask
	task automatic s_dt();
		dt(1'h1, 1'h0, 2'h2, 14'h5, 32'h0);
		expect_msg("dt min", mk(6'h0d, S1, 32'h2), 11, 2, 32'h5, 32'h0);
		dt(1'h0, 1'h0, 2'h1, 14'h7f, 32'h1f);
		expect_msg("dt ws", mk(6'h0d, S0, 32'h1), 11, 2, 32'h7f, 32'h1f);
		dt(1'h0, 1'h1, 2'h3, 14'h3fff, 32'h80000000);
		expect_msg("dt rd", mk(6'h06, S0, 32'h3), 11, 2, 32'h3fff, 32'h80000000);
		@(posedge sys_clk);
		ev0.in_debug <= 1'h1;
		@(posedge sys_clk);
		ev0.in_debug <= 1'h0;
		repeat (3) @(posedge sys_clk);
		chk_reg("psync exit", 32'h3, 32'(pt_sync_req));
		dt(1'h0, 1'h0, 2'h0, 14'h1, 32'h1);
		expect_msg("dt resync", mk(6'h0d, S0, 32'h0), 11, 2, 32'h1, 32'h1);
		dt(1'h1, 1'h1, 2'h1, 14'h2, 32'h2);
		expect_msg("dt other", mk(6'h06, S1, 32'h1), 11, 2, 32'h2, 32'h2);
	endtask
	task automatic s_overrun();
		int i;
		@(posedge sys_clk);
		aux_grant <= 1'h0;
		for (i = 0; i < 14; i++)
		begin
			@(posedge sys_clk);
			ev0.debug_status_word <= 32'h100 + 32'(i);
		end
		bus(1'h0, 8'h04, 32'h0);
		chk_reg("ovr", 32'h0a04, rd & 32'hff07);
		chk_reg("req", 32'h1, 32'(aux_req));
		aux_grant <= 1'h1;
		// Queue closes at ten entries, so exactly ten status messages precede the error
		for (i = 0; i < 10; i++)
			expect_msg("ds queued", mk(6'h00, S0, 32'h100 + 32'(i)), 41, 0, 0, 0);
		expect_msg("err", mk(6'h08, S0, 32'h18), 14, 0, 0, 0);
		bus(1'h0, 8'h04, 32'h0);
		chk_reg("ovr clr", 32'h3, rd & 32'h7);
	endtask
	// Hang guard, well past the expected run length
	initial
	begin
		#400000;
		miscompares++;
		complete_run();
	end
	// Main sequence: 16 pins first, then a second reset at 8 pins and a third at 4 pins
	initial
	begin
		do_reset(2'h2);
		s_regs(32'h000200f3);
		s_ot();
		s_dt();
		s_overrun();
		do_reset(2'h1);
		w = 8;
		s_regs(32'h000100f3);
		dt(1'h0, 1'h0, 2'h0, 14'h3, 32'h1ff);
		expect_msg("dt 8 pins", mk(6'h0d, S0, 32'h0), 11, 2, 32'h3, 32'h1ff);
		do_reset(2'h0);
		w = 4;
		s_regs(32'h000000f3);
		dt(1'h1, 1'h1, 2'h2, 14'h1a, 32'h6);
		expect_msg("dt 4 pins", mk(6'h0e, S1, 32'h2), 11, 2, 32'h1a, 32'h6);
		complete_run();
	end
endmodule // trace_message_formatter_test
